// [rtl/lmx_move_exec.sv]
// How it works
// RL1: bank literal loads bank register, flags kept
// RL2: page literal loads pc high latch
// RL3: work literal loads working register, one cycle
// RL4: store work to 7-bit file address
// RL5: indirect address: pointer, pointer plus one, minus one, offset
// RL6: pointer ends incremented, decremented or unchanged
// RL7: mode 00/01/10/11 pre/post increment/decrement
// RL8: window registers reach location at selected pointer
// RL9: 16-bit pointers wrap around at both ends
// RL10: pointer update touches no status flag
// RL11: idle instruction changes nothing, one cycle
// RL12: literal load and file store take one cycle
module lmx_move_exec (
  // clock and reset
  input  wire logic                mclk_in,
  input  wire logic                srst_in,
  // raw instruction word and valid bit from the fetch stage, decoded here
  input  wire lmx_pkg::lmx_instr_s instr_in,
  // core registers
  output logic [5:0]               bank_select_reg_out,
  output logic [6:0]               pc_high_latch_out,
  output logic [7:0]               work_reg_out,
  output logic [1:0][15:0]         file_select_pointer_out,
  // data memory write port
  output lmx_pkg::lmx_wr_s         mem_wr_out,
  // completion
  output logic                     done_out
);

  // ****************************************
  // decode
  // ****************************************
  function automatic logic op_is(input logic [13:0] w, input logic [13:0] op, input logic [13:0] msk);
    op_is = (w & msk) == op;
  endfunction

  lmx_pkg::lmx_state_s s_q;
  lmx_pkg::lmx_state_s s_d;

  logic        v;
  logic [13:0] w;
  logic        is_idle;
  logic        is_bank;
  logic        is_page;
  logic        is_work;
  logic        is_file;
  logic        is_ind;
  logic        is_rel;
  logic        is_win;
  logic        sel;
  logic [15:0] sel_ptr;
  logic [15:0] pu_addr;
  logic [15:0] pu_next;
  logic        is_none;
  logic [15:0] win_ptr;
  logic [15:0] oth_ptr;

  assign v       = instr_in.valid;
  assign w       = instr_in.word;
  assign is_idle = v && op_is(w, lmx_pkg::OP_IDLE, lmx_pkg::MSK_IDLE);
  assign is_bank = v && op_is(w, lmx_pkg::OP_BANK, lmx_pkg::MSK_BANK);
  assign is_page = v && op_is(w, lmx_pkg::OP_PAGE, lmx_pkg::MSK_PAGE);
  assign is_work = v && op_is(w, lmx_pkg::OP_WORK, lmx_pkg::MSK_WORK);
  assign is_file = v && op_is(w, lmx_pkg::OP_FILE, lmx_pkg::MSK_FILE);
  assign is_ind  = v && op_is(w, lmx_pkg::OP_IND, lmx_pkg::MSK_IND);
  assign is_rel  = v && op_is(w, lmx_pkg::OP_REL, lmx_pkg::MSK_REL);
  assign is_win  = (w[6:0] == lmx_pkg::WIN0_ADDR) || (w[6:0] == lmx_pkg::WIN1_ADDR);
  assign sel     = is_rel ? w[lmx_pkg::REL_SEL_BIT] : w[lmx_pkg::IND_SEL_BIT];
  assign sel_ptr = s_q.ptr[sel];
  assign win_ptr = s_q.ptr[w[0]];
  assign oth_ptr = s_q.ptr[!sel];
  // words outside every encoding still complete, but move nothing
  assign is_none = v && !(is_idle || is_bank || is_page || is_work || is_file || is_ind || is_rel);

  lmx_ptr_unit u_ptr (
    .ptr_in    (sel_ptr),
    .mode_in   (w[1:0]),
    .rel_in    (is_rel),
    .offset_in (w[5:0]),
    .addr_out  (pu_addr),
    .next_out  (pu_next)
  );

  // ****************************************
  // next state
  // ****************************************
  // the block owns no status bits, so no path here can disturb them
  always_comb begin
    s_d         = s_q;
    s_d.wr.en   = 1'b0;
    s_d.done    = v;                                            // RL12 RL11
    if (is_bank) begin
      s_d.bank = w[5:0];                                        // RL1
    end else if (is_page) begin
      s_d.page = w[6:0];                                        // RL2
    end else if (is_work) begin
      s_d.work = w[7:0];                                        // RL3
    end else if (is_file) begin
      s_d.wr.en   = 1'b1;
      s_d.wr.data = s_q.work;                                   // RL4
      if (is_win) begin
        s_d.wr.addr = s_q.ptr[w[0]];                            // RL8
      end else begin
        s_d.wr.addr = {3'b000, s_q.bank, w[6:0]};               // RL4
      end
    end else if (is_ind || is_rel) begin
      s_d.wr.en      = 1'b1;
      s_d.wr.data    = s_q.work;
      s_d.wr.addr    = pu_addr;                                 // RL5 RL7
      s_d.ptr[sel]   = pu_next;                                 // RL6 RL9 RL10
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      s_q.bank    <= lmx_pkg::BANK_RST;
      s_q.page    <= lmx_pkg::PAGE_RST;
      s_q.work    <= lmx_pkg::WORK_RST;
      s_q.ptr     <= {lmx_pkg::PTR_RST, lmx_pkg::PTR_RST};
      s_q.wr      <= '0;
      s_q.done    <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign bank_select_reg_out     = s_q.bank;
  assign pc_high_latch_out       = s_q.page;
  assign work_reg_out            = s_q.work;
  assign file_select_pointer_out = s_q.ptr;
  assign mem_wr_out              = s_q.wr;
  assign done_out                = s_q.done;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (srst_in);

  sequence seq_idle_issue;
    is_idle;
  endsequence

  sequence seq_quiet;
    !s_q.wr.en && $stable(s_q.bank) && $stable(s_q.page) && $stable(s_q.work) && $stable(s_q.ptr);
  endsequence

  sequence seq_wrap_inc;
    is_ind && (w[1:0] == 2'b10) && (sel_ptr == 16'hffff);
  endsequence

  sequence seq_ind_issue;
    is_ind || is_rel;
  endsequence

  sequence seq_store_out;
    s_q.wr.en && s_q.wr.data == $past(s_q.work) && done_out;
  endsequence

  a_bank_load: assert property (is_bank |=> s_q.bank == $past(w[5:0]) && !s_q.wr.en) // RL1
    else $error("bank register not loaded");
  a_page_load: assert property (is_page |=> s_q.page == $past(w[6:0]) && $stable(s_q.bank)) // RL2
    else $error("page latch not loaded");
  a_work_load: assert property (is_work |=> s_q.work == $past(w[7:0]) && done_out) // RL3
    else $error("work register not loaded");
  a_file_store: assert property (is_file && !is_win |=> s_q.wr.en && s_q.wr.data == $past(s_q.work) // RL4
                                 && s_q.wr.addr == {3'b000, $past(s_q.bank), $past(w[6:0])})
    else $error("file store wrong");
  a_window_store: assert property (is_file && is_win |=> s_q.wr.en && s_q.wr.addr == $past(win_ptr) // RL8
                                   && $stable(s_q.ptr))
    else $error("window store wrong");
  a_pre_inc_addr: assert property (is_ind && w[1:0] == 2'b00 |=> // RL5
                                   s_q.wr.addr == 16'($past(sel_ptr) + 16'h0001)
                                   && s_q.wr.addr == s_q.ptr[$past(sel)])
    else $error("preincrement address wrong");
  a_pre_dec_addr: assert property (is_ind && w[1:0] == 2'b01 |=> // RL5
                                   s_q.wr.addr == 16'($past(sel_ptr) - 16'h0001)
                                   && s_q.wr.addr == s_q.ptr[$past(sel)])
    else $error("predecrement address wrong");
  a_post_inc_ptr: assert property (is_ind && w[1:0] == 2'b10 |=> // RL7
                                   s_q.wr.addr == $past(sel_ptr)
                                   && s_q.ptr[$past(sel)] == 16'($past(sel_ptr) + 16'h0001))
    else $error("postincrement wrong");
  a_post_dec_ptr: assert property (is_ind && w[1:0] == 2'b11 |=> // RL7
                                   s_q.wr.addr == $past(sel_ptr)
                                   && s_q.ptr[$past(sel)] == 16'($past(sel_ptr) - 16'h0001))
    else $error("postdecrement wrong");
  a_rel_keep_ptr: assert property (is_rel |=> $stable(s_q.ptr) // RL6
                                   && s_q.wr.addr == 16'($past(sel_ptr) + {{10{$past(w[5])}}, $past(w[5:0])}))
    else $error("relative store wrong");
  a_ptr_wrap: assert property (seq_wrap_inc |=> s_q.ptr[$past(sel)] == 16'h0000) // RL9
    else $error("pointer did not wrap");
  a_idle_quiet: assert property (seq_idle_issue |=> seq_quiet and done_out) // RL11
    else $error("idle instruction changed state");
  a_one_cycle: assert property (v |=> done_out ##1 (done_out == $past(v))) // RL12
    else $error("completion not in one cycle");

  // store data and the unselected pointer left alone
  a_store_data: assert property (seq_ind_issue |=> seq_store_out) // RL5
    else $error("indirect store data wrong");
  a_other_ptr: assert property (seq_ind_issue |=> s_q.ptr[!$past(sel)] == $past(oth_ptr)) // RL6
    else $error("unselected pointer moved");

  // registers move only on their own instruction
  a_bank_hold: assert property (!is_bank |=> $stable(s_q.bank)) // RL1
    else $error("bank register changed");
  a_page_hold: assert property (!is_page |=> $stable(s_q.page)) // RL2
    else $error("page latch changed");
  a_work_hold: assert property (!is_work |=> $stable(s_q.work)) // RL3
    else $error("work register changed");
  a_ptr_hold: assert property (!is_ind |=> $stable(s_q.ptr)) // RL10
    else $error("pointer changed without indirect store");
  a_store_strobe: assert property (!(is_file || is_ind || is_rel) |=> !s_q.wr.en) // RL4
    else $error("write strobe without a store");
  a_unknown_quiet: assert property (is_none |=> seq_quiet and done_out) // RL11
    else $error("unknown word changed state");
  a_no_issue_quiet: assert property (!v |=> seq_quiet and !done_out) // RL11
    else $error("state changed without an instruction");

endmodule

// [rtl/lmx_pkg.sv]
package lmx_pkg;

  // ****************************************
  // instruction word and opcode patterns
  // ****************************************
  localparam int          INSTR_W    = 14;
  localparam logic [13:0] OP_IDLE    = 14'h0000;
  localparam logic [13:0] MSK_IDLE   = 14'h3fff;
  localparam logic [13:0] OP_BANK    = 14'h0140;
  localparam logic [13:0] MSK_BANK   = 14'h3fc0;
  localparam logic [13:0] OP_PAGE    = 14'h3180;
  localparam logic [13:0] MSK_PAGE   = 14'h3f80;
  localparam logic [13:0] OP_WORK    = 14'h3000;
  localparam logic [13:0] MSK_WORK   = 14'h3f00;
  localparam logic [13:0] OP_FILE    = 14'h0080;
  localparam logic [13:0] MSK_FILE   = 14'h3f80;
  localparam logic [13:0] OP_IND     = 14'h0018;
  localparam logic [13:0] MSK_IND    = 14'h3ff8;
  localparam logic [13:0] OP_REL     = 14'h3f80;
  localparam logic [13:0] MSK_REL    = 14'h3f80;

  // ****************************************
  // field positions
  // ****************************************
  localparam int IND_SEL_BIT = 2;
  localparam int REL_SEL_BIT = 6;

  // ****************************************
  // addresses of the two window registers
  // ****************************************
  localparam logic [6:0] WIN0_ADDR = 7'h00;
  localparam logic [6:0] WIN1_ADDR = 7'h01;

  // ****************************************
  // widths and reset values
  // ****************************************
  localparam int          BANK_W     = 6;
  localparam int          PAGE_W     = 7;
  localparam int          PTR_W      = 16;
  localparam logic [5:0]  BANK_RST   = 6'h00;
  localparam logic [6:0]  PAGE_RST   = 7'h00;
  localparam logic [7:0]  WORK_RST   = 8'h00;
  localparam logic [15:0] PTR_RST    = 16'h0000;

  typedef enum logic [1:0] {
    LMX_PRE_INC  = 2'b00,
    LMX_PRE_DEC  = 2'b01,
    LMX_POST_INC = 2'b10,
    LMX_POST_DEC = 2'b11
  } lmx_mode_e;

  typedef struct packed {
    logic        valid;
    logic [13:0] word;
  } lmx_instr_s;

  typedef struct packed {
    logic        en;
    logic [15:0] addr;
    logic [7:0]  data;
  } lmx_wr_s;

  typedef struct packed {
    logic [5:0]       bank;
    logic [6:0]       page;
    logic [7:0]       work;
    logic [1:0][15:0] ptr;
    lmx_wr_s          wr;
    logic             done;
  } lmx_state_s;

endpackage

// [rtl/lmx_ptr_unit.sv]
module lmx_ptr_unit (
  // pointer and operand
  input  wire logic [15:0] ptr_in,
  input  wire logic [1:0]  mode_in,
  input  wire logic        rel_in,
  input  wire logic [5:0]  offset_in,
  // results
  output logic      [15:0] addr_out,
  output logic      [15:0] next_out
);

  logic [15:0] inc;
  logic [15:0] dec;
  logic [15:0] rel;

  // 16-bit sums wrap on their own, no status is produced
  assign inc = ptr_in + 16'h0001;                              // RL9 RL10
  assign dec = ptr_in - 16'h0001;                              // RL9 RL10
  assign rel = ptr_in + {{10{offset_in[5]}}, offset_in};       // RL5

  always_comb begin
    addr_out = rel;
    next_out = ptr_in;
    if (!rel_in) begin
      unique case (lmx_pkg::lmx_mode_e'(mode_in))              // RL7
        lmx_pkg::LMX_PRE_INC: begin
          addr_out = inc;
          next_out = inc;
        end
        lmx_pkg::LMX_PRE_DEC: begin
          addr_out = dec;
          next_out = dec;
        end
        lmx_pkg::LMX_POST_INC: begin
          addr_out = ptr_in;
          next_out = inc;
        end
        lmx_pkg::LMX_POST_DEC: begin
          addr_out = ptr_in;
          next_out = dec;
        end
      endcase
    end
  end                                                          // RL6

endmodule

// [test/literal_and_indirect_move_exec_test.sv]
module literal_and_indirect_move_exec_test;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // design signals
  // ****************************************
  logic                mclk_in  = 1'b0;
  logic                srst_in  = 1'b1;
  lmx_pkg::lmx_instr_s instr_in = '0;
  logic [5:0]          bank;
  logic [6:0]          page;
  logic [7:0]          work;
  logic [1:0][15:0]    ptr;
  lmx_pkg::lmx_wr_s    wr;
  logic                done;
  logic [31:0]         wr_count;

  // ****************************************
  // expected state
  // ****************************************
  logic [5:0]       e_bank = '0;
  logic [6:0]       e_page = '0;
  logic [7:0]       e_work = '0;
  logic [1:0][15:0] e_ptr  = '0;
  logic             e_en   = 1'b0;
  logic             e_done = 1'b0;
  logic [15:0]      e_addr = '0;
  logic [7:0]       e_data = '0;
  logic [31:0]      e_count = '0;
  int               errors = 0;
  int               checked = 0;
  int               cycles = 0;
  int               seed = 32'h1d23;
  // wraps at both ends, window 0 store, offset limits, unknown word
  logic [13:0]      corner [13] = '{14'h0000, 14'h0019, 14'h0018, 14'h017f, 14'h30a5, 14'h0085, 14'h0080,
                                    14'h001f, 14'h001e, 14'h3fe0, 14'h3f9f, 14'h31ff, 14'h2000};

  lmx_move_exec DUT (
    .mclk_in                 (mclk_in),
    .srst_in                 (srst_in),
    .instr_in                (instr_in),
    .bank_select_reg_out     (bank),
    .pc_high_latch_out       (page),
    .work_reg_out            (work),
    .file_select_pointer_out (ptr),
    .mem_wr_out              (wr),
    .done_out                (done)
  );

  lmx_mem_model mem_model (
    .mclk_in   (mclk_in),
    .wr_in     (wr),
    .count_out (wr_count)
  );

  always #5 mclk_in = ~mclk_in;

  // ****************************************
  // checking
  // ****************************************
  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp1(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic predict(input logic [13:0] w);
    logic [15:0] p;
    e_en = 1'b0;
    e_done = 1'b1;
    e_data = e_work;
    if ((w & lmx_pkg::MSK_BANK) == lmx_pkg::OP_BANK) e_bank = w[5:0];
    else if ((w & lmx_pkg::MSK_PAGE) == lmx_pkg::OP_PAGE) e_page = w[6:0];
    else if ((w & lmx_pkg::MSK_WORK) == lmx_pkg::OP_WORK) e_work = w[7:0];
    else if ((w & lmx_pkg::MSK_FILE) == lmx_pkg::OP_FILE) begin
      e_en = 1'b1;
      e_addr = (w[6:1] == 6'h00) ? e_ptr[w[0]] : {3'h0, e_bank, w[6:0]};
    end else if ((w & lmx_pkg::MSK_IND) == lmx_pkg::OP_IND) begin
      p = e_ptr[w[2]];
      e_en = 1'b1;
      e_addr = w[1] ? p : (w[0] ? p - 16'h1 : p + 16'h1);
      e_ptr[w[2]] = w[0] ? p - 16'h1 : p + 16'h1;
    end else if ((w & lmx_pkg::MSK_REL) == lmx_pkg::OP_REL) begin
      e_en = 1'b1;
      e_addr = e_ptr[w[6]] + {{10{w[5]}}, w[5:0]};
    end
  endtask

  // check the previous issue, then present the next one
  task automatic step(input logic v, input logic [13:0] w);
    @(negedge mclk_in);
    cmp16({10'h0, bank}, {10'h0, e_bank});
    cmp16({9'h0, page}, {9'h0, e_page});
    cmp16({8'h0, work}, {8'h0, e_work});
    cmp16(ptr[0], e_ptr[0]);
    cmp16(ptr[1], e_ptr[1]);
    cmp1(done, e_done);
    cmp1(wr.en, e_en);
    cmp16(wr_count[15:0], e_count[15:0]);
    if (e_en) begin
      cmp16(wr.addr, e_addr);
      cmp16({8'h0, wr.data}, {8'h0, e_data});
      e_count = e_count + 32'h1;
    end
    instr_in.valid = v;
    instr_in.word = w;
    e_en = 1'b0;
    e_done = 1'b0;
    if (v) predict(w);
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  always @(posedge mclk_in) begin
    cycles++;
    if (cycles >= 5000) begin
      errors++;
      print_verdict();
    end
  end

  initial begin
    logic [31:0] r;
    logic [13:0] w;
    repeat (5) @(negedge mclk_in);
    srst_in = 1'b0;
    foreach (corner[i]) step(1'b1, corner[i]);
    for (int i = 0; i < 2000; i++) begin
      r = $random(seed);
      case (r[23:21])
        3'h0: w = lmx_pkg::OP_BANK | {8'h0, r[5:0]};
        3'h1: w = lmx_pkg::OP_PAGE | {7'h0, r[6:0]};
        3'h2: w = lmx_pkg::OP_WORK | {6'h0, r[7:0]};
        3'h3: w = lmx_pkg::OP_FILE | {7'h0, r[6:0]};
        3'h4: w = lmx_pkg::OP_IND | {11'h0, r[2:0]};
        3'h5: w = lmx_pkg::OP_REL | {7'h0, r[6:0]};
        3'h6: w = r[13:0];
        default: w = lmx_pkg::OP_IDLE;
      endcase
      step(r[26:24] != 3'h0, w);
    end
    step(1'b0, 14'h0000);
    // mid-run reset: every register falls back to its reset value
    srst_in = 1'b1;
    repeat (2) @(negedge mclk_in);
    srst_in = 1'b0;
    e_bank = lmx_pkg::BANK_RST;
    e_page = lmx_pkg::PAGE_RST;
    e_work = lmx_pkg::WORK_RST;
    e_ptr  = {lmx_pkg::PTR_RST, lmx_pkg::PTR_RST};
    foreach (corner[i]) step(1'b1, corner[i]);
    step(1'b0, 14'h0000);
    step(1'b0, 14'h0000);
    print_verdict();
  end
endmodule

// [test/lmx_mem_model.sv]
module lmx_mem_model (
  // clock
  input  wire logic             mclk_in,
  // write port from the core
  input  wire lmx_pkg::lmx_wr_s wr_in,
  // statistics
  output logic [31:0]           count_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // sparse store: the whole 64k space would waste memory in simulation
  logic [7:0] mem [logic [15:0]];

  initial count_out = 32'h0;

  always @(posedge mclk_in) begin
    if (wr_in.en === 1'b1) begin
      mem[wr_in.addr] = wr_in.data;
      count_out <= count_out + 32'h1;
    end
  end
endmodule
